// *** link_demux_model.sv ***
`default_nettype none
// ==========================================================
// Link demultiplexer stand-in
module link_demux_model (
   // Clock
   input wire logic clk,
   // Timing records
   output logic tmValid,
   output logic [31:0] tmEmitTime,
   output logic [15:0] tmSyncCfg,
   output logic [2:0] tmCopies,
   output logic [2:0] tmPreCopies,
   output logic [7:0] tmTxId,
   output logic [7:0] tmIdLevel,
   output logic [31:0] tmTxOffset,
   // Preamble bytes
   output logic preValid,
   output logic preFirst,
   output logic [7:0] preData,
   output logic [31:0] preEmitTime
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle at start
   initial
   begin
      {tmValid, tmEmitTime, tmSyncCfg, tmCopies, tmPreCopies} = '0;
      {tmTxId, tmIdLevel, tmTxOffset, preValid, preFirst, preData, preEmitTime} = '0;
   end
   // One record, sent well ahead of its frame; emit time and sync config inverted once released
   task automatic sendRecord(input logic [31:0] e, input logic [15:0] cfg,
      input logic [2:0] cps, input logic [7:0] id, input logic [7:0] lvl,
      input logic [31:0] off);
      @(posedge clk);
      #1;
      tmValid = 1'b1;
      tmEmitTime = e;
      {tmSyncCfg, tmCopies, tmPreCopies, tmTxId, tmIdLevel, tmTxOffset} = {cfg, cps, cps, id, lvl, off};
      @(posedge clk);
      #1;
      tmValid = 1'b0;
      tmEmitTime = ~tmEmitTime;
      tmSyncCfg = ~tmSyncCfg;
   endtask : sendRecord
   // Whole preamble copy, one byte a cycle, stamped with its frame time
   task automatic sendPre(input logic [31:0] e, input logic [7:0] b[$]);
      for (int i = 0; i < b.size(); i++)
      begin
         @(posedge clk);
         #1;
         preValid = 1'b1;
         preFirst = (i == 0);
         preData = b[i];
         preEmitTime = e;
      end
      @(posedge clk);
      #1;
      preValid = 1'b0;
      preFirst = 1'b0;
      preData = ~preData;
   endtask : sendPre
endmodule : link_demux_model
`default_nettype wire

// *** pre_store.sv ***
`default_nettype none
// ==========================================================
// Preamble byte store, registered read port
module pre_store #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [7:0] wrData,
   // Read port
   input wire logic [AW-1:0] rdAddr,
   output logic [7:0] rdData
);
   logic [7:0] mem [DEPTH];
   // Memory write and registered read
   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : pre_store
`default_nettype wire

// *** transmitter_timing_and_preamble_control_test.sv ***
`default_nettype none
// ==========================================================
// Bench top
module transmitter_timing_and_preamble_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic refPps = 1'b0;
   logic [31:0] refTime = 32'h0;
   logic [31:0] apDelay = 32'h0000000A;
   logic [31:0] linkDelay = 32'h00000040;
   logic tmValid, preValid, preFirst, frameStart, idSigOn, tmError, preOutValid, stageValid;
   logic [31:0] tmEmitTime, tmTxOffset, preEmitTime;
   logic [15:0] tmSyncCfg, syncCfg;
   logic [2:0] tmCopies, tmPreCopies, preCopyCount;
   logic [7:0] tmTxId, tmIdLevel, preData, idSigLevel, preOutData, stageData;
   logic [1:0] stageSel;
   logic [31:0] freqRefTime, dataPathDelay;
   logic preError;
   logic [7:0] pre[$] = '{8'h00, 8'h04, 8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h3C, 8'h5E};
   logic [7:0] pay[$] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
   logic [7:0] none[$];
   int fail_count = 0;
   int n_checks = 0;
   // Clock and free-running time reference
   always #50 clk = ~clk;
   always @(posedge clk)
   begin
      #1;
      refTime = refTime + 32'h1;
      refPps = refTime[4];
   end
   link_demux_model link_u (.clk(clk), .tmValid(tmValid), .tmEmitTime(tmEmitTime),
      .tmSyncCfg(tmSyncCfg), .tmCopies(tmCopies), .tmPreCopies(tmPreCopies),
      .tmTxId(tmTxId), .tmIdLevel(tmIdLevel), .tmTxOffset(tmTxOffset), .preValid(preValid),
      .preFirst(preFirst), .preData(preData), .preEmitTime(preEmitTime));
   tx_timing_ctl dut_u (.clk(clk), .sys_rst(sysRst), .refTime(refTime), .refPps(refPps),
      .tmValid(tmValid), .tmEmitTime(tmEmitTime), .tmSyncCfg(tmSyncCfg), .tmCopies(tmCopies),
      .tmPreCopies(tmPreCopies), .tmTxId(tmTxId), .tmTxOffset(tmTxOffset),
      .tmIdLevel(tmIdLevel), .tmLinkDelay(linkDelay), .antennaPathDelay(apDelay),
      .preValid(preValid), .preFirst(preFirst), .preData(preData), .preEmitTime(preEmitTime),
      .frameStart(frameStart), .syncCfg(syncCfg), .freqRefTime(freqRefTime), .freqRefPps(),
      .dataPathDelay(dataPathDelay), .idSigLevel(idSigLevel), .idSigOn(idSigOn),
      .preCopyCount(preCopyCount), .tmError(tmError), .preOutValid(preOutValid),
      .preOutData(preOutData), .stageValid(stageValid), .stageSel(stageSel),
      .stageData(stageData), .preError(preError));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // Bounded wait for frame start, then judge its moment against the due time
   task automatic waitFrame(input logic [31:0] due);
      int i;
      for (i = 0; i < 1000 && frameStart !== 1'b1; i++)
         @(posedge clk) #2;
      if (i == 1000)
      begin
         fail_count++;
         test_done();
      end
      check((refTime - due) >= 32'h1 && (refTime - due) <= 32'h5, 1'b1);
   endtask : waitFrame
   // Payload bytes in order, stage select walking, no length or check word
   task automatic grabPre(input logic [7:0] exp[$]);
      int np = 0;
      int ns = 0;
      repeat (24)
      begin
         @(posedge clk) #2;
         if (preOutValid === 1'b1)
         begin
            check(preOutData, exp[np]);
            np++;
         end
         if (stageValid === 1'b1)
         begin
            check({stageSel, stageData}, {ns[1:0], exp[ns]});
            ns++;
         end
      end
      check(np, exp.size());
   endtask : grabPre
   task automatic tReset();
      check({idSigLevel, preCopyCount, frameStart, tmError}, {8'h00, 3'h1, 2'h0});
   endtask : tReset
   // Two of three copies agree; offset and antenna delay shift the frame
   task automatic tVoteOk();
      logic [31:0] e;
      e = refTime + 32'h12C;
      link_u.sendRecord(e, 16'hA55A, 3'h3, 8'h00, 8'h5A, 32'h14);
      link_u.sendRecord(e, 16'h0F0F, 3'h3, 8'h00, 8'h5A, 32'h14);
      link_u.sendRecord(e, 16'hA55A, 3'h3, 8'h00, 8'h5A, 32'h14);
      repeat (3) link_u.sendPre(e, pre);
      waitFrame(e + 32'h14 - apDelay);
      check(syncCfg, 16'hA55A);
      check({idSigOn, idSigLevel}, {1'b1, 8'h5A});
      check(preCopyCount, 3'h3);
      check(tmError, 1'b0);
      check(dataPathDelay, linkDelay);
      check(refTime - freqRefTime, 32'h3);
      grabPre(pay);
      check(preError, 1'b0);
   endtask : tVoteOk
   // No two copies agree: error raised, old config kept; lone preamble copy flagged
   task automatic tVoteBad();
      logic [31:0] e;
      e = refTime + 32'h12C;
      link_u.sendRecord(e, 16'h1111, 3'h3, 8'h00, 8'h5A, 32'h0);
      link_u.sendRecord(e, 16'h2222, 3'h3, 8'h00, 8'h5A, 32'h0);
      link_u.sendRecord(e, 16'h3333, 3'h3, 8'h00, 8'h5A, 32'h0);
      link_u.sendPre(e, pre);
      waitFrame(e - apDelay);
      check({tmError, syncCfg}, {1'b1, 16'hA55A});
      grabPre(pay);
      check(preError, 1'b1);
   endtask : tVoteBad
   // Record meant for another transmitter must not start a frame
   task automatic tOtherTx();
      int n = 0;
      link_u.sendRecord(refTime + 32'h40, 16'h7777, 3'h1, 8'h07, 8'h00, 32'h0);
      repeat (200)
      begin
         @(posedge clk) #2;
         n += (frameStart === 1'b1);
      end
      check(n, 0);
      grabPre(none);
   endtask : tOtherTx
   initial
   begin
      repeat (5) @(posedge clk);
      #1 sysRst = 1'b0;
      tReset();
      tVoteOk();
      tVoteBad();
      tOtherTx();
      test_done();
   end
endmodule : transmitter_timing_and_preamble_control_test
`default_nettype wire

// *** tx_timing_ctl.sv ***
`include "txctl_defs.svh"
`default_nettype none
// ==========================================================
// Transmitter timing manager and preamble parser
module tx_timing_ctl #(
   parameter int TM_DEPTH = 4,
   parameter int PRE_DEPTH = 256,
   parameter int PRE_AW = 8,
   parameter int SYNC_CFG_W = 16,
   parameter int MY_TX_ID = 0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // External time reference (seconds-aligned count and pulse)
   input wire logic [31:0] refTime,
   input wire logic refPps,
   // Timing record stream from the link demultiplexer
   input wire logic tmValid,
   input wire logic [31:0] tmEmitTime,
   input wire logic [SYNC_CFG_W-1:0] tmSyncCfg,
   input wire logic [2:0] tmCopies,
   input wire logic [2:0] tmPreCopies,
   input wire logic [7:0] tmTxId,
   input wire logic [31:0] tmTxOffset,
   input wire logic [7:0] tmIdLevel,
   input wire logic [31:0] tmLinkDelay,
   // Local setting
   input wire logic [31:0] antennaPathDelay,
   // Preamble byte stream
   input wire logic preValid,
   input wire logic preFirst,
   input wire logic [7:0] preData,
   input wire logic [31:0] preEmitTime,
   // Sync symbol control out
   output logic frameStart,
   output logic [SYNC_CFG_W-1:0] syncCfg,
   output logic [31:0] freqRefTime,
   output logic freqRefPps,
   output logic [31:0] dataPathDelay,
   output logic [7:0] idSigLevel,
   output logic idSigOn,
   output logic [2:0] preCopyCount,
   output logic tmError,
   // Preamble to inserter and stages
   output logic preOutValid,
   output logic [7:0] preOutData,
   output logic stageValid,
   output logic [1:0] stageSel,
   output logic [7:0] stageData,
   output logic preError
);
   // ==========================================================
   // Synchronise the external reference inputs
   // Limitation: a binary count torn across the flops can miss a frame; send gray or held words
   logic [31:0] refT1_q, refT2_q;
   logic pps1_q, pps2_q;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         refT1_q <= 32'h0000_0000;
         refT2_q <= 32'h0000_0000;
         pps1_q <= 1'b0;
         pps2_q <= 1'b0;
      end
      else
      begin
         refT1_q <= refTime;
         refT2_q <= refT1_q;
         pps1_q <= refPps;
         pps2_q <= pps1_q;
      end
   end

   // ==========================================================
   // State
   typedef struct packed {
      logic [TM_DEPTH-1:0] slotUsed;
      logic [TM_DEPTH-1:0][31:0] slotTime;
      logic [TM_DEPTH-1:0][SYNC_CFG_W-1:0] slotCfg;
      logic [TM_DEPTH-1:0][2:0] slotVotes;
      logic [TM_DEPTH-1:0][2:0] slotCopies;
      logic [TM_DEPTH-1:0][2:0] slotPreCnt;
      logic frameStart;
      logic [SYNC_CFG_W-1:0] syncCfg;
      logic [31:0] dataPathDelay;
      logic [7:0] idSigLevel;
      logic idSigOn;
      logic [2:0] preCopyCount;
      logic tmError;
      txctl_pkg::pre_state_e preState;
      logic [PRE_AW-1:0] wrPtr;
      logic [PRE_AW-1:0] rdPtr;
      logic [15:0] preLen;
      logic [31:0] preTime;
      logic [2:0] preSeen;
      logic preOutValid;
      logic preError;
      logic [1:0] stageSel;
      logic stageValid;
      logic readPend;
   } state_s;
   state_s s_q, s_d;

   logic [7:0] rdByte;
   logic wrEn;
   pre_store #(.DEPTH(PRE_DEPTH), .AW(PRE_AW)) u_store (
      .clk(clk),
      .wrEn(wrEn),
      .wrAddr(s_q.wrPtr),
      .wrData(preData),
      .rdAddr(s_q.rdPtr),
      .rdData(rdByte)
   );

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      logic hit;
      logic [31:0] due;
      hit = 1'b0;
      due = 32'h0000_0000;
      s_d = s_q;
      s_d.frameStart = 1'b0;
      s_d.stageValid = 1'b0;
      s_d.preOutValid = 1'b0;
      wrEn = 1'b0;
      // Accept timing record; only our own transmitter id or broadcast 0
      if (tmValid && (tmTxId == 8'(MY_TX_ID) || tmTxId == 8'h00))
      begin
         s_d.idSigLevel = tmIdLevel;
         s_d.idSigOn = (tmIdLevel != 8'h00);
         s_d.dataPathDelay = tmLinkDelay;
         for (int i = 0; i < TM_DEPTH; i++)
         begin
            // Copy of a stored frame: matched by emission time plus transmitter offset
            if (!hit && s_q.slotUsed[i] && s_q.slotTime[i] == tmEmitTime + tmTxOffset)
            begin
               hit = 1'b1;
               if (s_q.slotCfg[i] == tmSyncCfg)
               begin
                  s_d.slotVotes[i] = s_q.slotVotes[i] + 3'h1;
               end
            end
         end
         for (int i = 0; i < TM_DEPTH; i++)
         begin
            // New frame takes a free slot; full buffer drops it
            if (!hit && !s_q.slotUsed[i])
            begin
               hit = 1'b1;
               s_d.slotUsed[i] = 1'b1;
               s_d.slotTime[i] = tmEmitTime + tmTxOffset;
               s_d.slotCfg[i] = tmSyncCfg;
               s_d.slotVotes[i] = 3'h1;
               s_d.slotCopies[i] = (tmCopies == 3'h0) ? `COPY_CNT_RST : tmCopies;
               s_d.slotPreCnt[i] = tmPreCopies;
            end
         end
      end
      // Frame start when stored time minus antenna delay reaches local time
      for (int i = 0; i < TM_DEPTH; i++)
      begin
         due = s_q.slotTime[i] - antennaPathDelay;
         if (s_q.slotUsed[i] && due == refT2_q)
         begin
            s_d.slotUsed[i] = 1'b0;
            s_d.frameStart = 1'b1;
            s_d.preCopyCount = s_q.slotPreCnt[i];
            // Majority needed, otherwise keep the old sync configuration
            if ({s_q.slotVotes[i], 1'b0} > {1'b0, s_q.slotCopies[i]})
            begin
               s_d.syncCfg = s_q.slotCfg[i];
               s_d.tmError = 1'b0;
            end
            else
            begin
               s_d.tmError = 1'b1;
            end
         end
      end
      // Preamble parser
      case (s_q.preState)
         txctl_pkg::PP_IDLE:
         begin
            if (preValid && preFirst)
            begin
               s_d.preLen = {8'h00, preData};
               s_d.preTime = preEmitTime;
               s_d.wrPtr = '0;
               s_d.preState = txctl_pkg::PP_LEN;
            end
         end
         txctl_pkg::PP_LEN:
         begin
            if (preValid)
            begin
               s_d.preLen = {s_q.preLen[7:0], preData};
               s_d.preState = txctl_pkg::PP_BODY;
            end
         end
         txctl_pkg::PP_BODY:
         begin
            if (preValid)
            begin
               wrEn = 1'b1;
               s_d.wrPtr = s_q.wrPtr + PRE_AW'(1);
               if (17'(s_q.wrPtr) + 17'd1 >= 17'(s_q.preLen) + 17'(`PRE_CHK_BYTES))
               begin
                  s_d.rdPtr = '0;
                  s_d.preSeen = 3'h1;
                  s_d.preState = txctl_pkg::PP_HOLD;
               end
            end
         end
         txctl_pkg::PP_HOLD:
         begin
            // Duplicate copy of same frame counts toward the vote
            if (preValid && preFirst && preEmitTime == s_q.preTime)
            begin
               s_d.preSeen = s_q.preSeen + 3'h1;
            end
            if (s_q.frameStart && !s_q.readPend)
            begin
               s_d.readPend = 1'b1;
               s_d.preError = (s_q.preCopyCount > 3'h1) &&
                  ({s_q.preSeen, 1'b0} <= {1'b0, s_q.preCopyCount});
            end
            else if (s_q.readPend)
            begin
               // One extra step flushes the read pipe; check word is never sent on
               if (17'(s_q.rdPtr) <= 17'(s_q.preLen))
               begin
                  s_d.rdPtr = s_q.rdPtr + PRE_AW'(1);
                  s_d.preOutValid = (s_q.rdPtr != '0);
                  s_d.stageValid = (s_q.rdPtr != '0);
                  s_d.stageSel = 2'(s_q.rdPtr - PRE_AW'(1));
               end
               else
               begin
                  s_d.readPend = 1'b0;
                  s_d.preState = txctl_pkg::PP_IDLE;
               end
            end
         end
         default:
         begin
            s_d.preState = txctl_pkg::PP_IDLE;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         s_q.preState <= txctl_pkg::PP_IDLE;
         s_q.idSigLevel <= `TX_ID_SIG_LEVEL_RST;
         s_q.preCopyCount <= `COPY_CNT_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Output registers; byte out lags read address by two cycles
   logic [7:0] preOutData_q;
   logic [31:0] freqRef_q;
   logic freqPps_q;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         preOutData_q <= 8'h00;
         freqRef_q <= 32'h0000_0000;
         freqPps_q <= 1'b0;
      end
      else
      begin
         preOutData_q <= rdByte;
         freqRef_q <= refT2_q;
         freqPps_q <= pps2_q;
      end
   end

   assign frameStart = s_q.frameStart;
   assign syncCfg = s_q.syncCfg;
   assign freqRefTime = freqRef_q;
   assign freqRefPps = freqPps_q;
   assign dataPathDelay = s_q.dataPathDelay;
   assign idSigLevel = s_q.idSigLevel;
   assign idSigOn = s_q.idSigOn;
   assign preCopyCount = s_q.preCopyCount;
   assign tmError = s_q.tmError;
   assign preOutValid = s_q.preOutValid;
   assign preOutData = preOutData_q;
   assign stageValid = s_q.stageValid;
   assign stageSel = s_q.stageSel;
   assign stageData = preOutData_q;
   assign preError = s_q.preError;
endmodule : tx_timing_ctl
`default_nettype wire

// *** tx_timing_props.sv ***
`default_nettype none
// ==========================================================
// Timing manager and preamble parser checker
module tx_timing_props #(
   parameter int SYNC_CFG_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Watched ports
   input wire logic refPps,
   input wire logic tmValid,
   input wire logic frameStart,
   input wire logic [SYNC_CFG_W-1:0] syncCfg,
   input wire logic freqRefPps,
   input wire logic [7:0] idSigLevel,
   input wire logic idSigOn,
   input wire logic [2:0] preCopyCount,
   input wire logic tmError,
   input wire logic preOutValid,
   input wire logic stageValid,
   input wire logic [1:0] stageSel
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [3:0] sinceFs;
   // Saturates high, so output with no frame before it is caught
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         sinceFs <= 4'hF;
      else if (frameStart)
         sinceFs <= 4'h0;
      else if (sinceFs != 4'hF)
         sinceFs <= sinceFs + 4'h1;
   end
   // Two stage bytes in a row
   sequence sStageStep;
      stageValid ##1 stageValid;
   endsequence
   AST_FS_PULSE: assert property (frameStart |=> !frameStart)
      else $error("frame start wider than one cycle");
   AST_IDSIG_ON: assert property (idSigOn == (idSigLevel != 8'h00))
      else $error("id signal enable disagrees with level");
   AST_PRE_AFTER_FS: assert property ($rose(preOutValid) |-> sinceFs <= 4'h5)
      else $error("preamble output not right after frame start");
   AST_STAGE_AFTER_FS: assert property ($rose(stageValid) |-> sinceFs <= 4'h6)
      else $error("stage instruction not tied to frame start");
   AST_STAGE_STEP: assert property (sStageStep |-> stageSel == $past(stageSel) + 2'h1)
      else $error("stage select did not advance");
   AST_SYNC_HOLD: assert property ($changed(syncCfg) |-> frameStart || $past(frameStart))
      else $error("sync config changed between frames");
   AST_ERR_HOLD: assert property ($changed(tmError) |-> frameStart || $past(frameStart))
      else $error("timing error changed between frames");
   AST_COPY_FWD: assert property ($changed(preCopyCount) |->
      $past(tmValid) || $past(tmValid, 2) || frameStart || $past(frameStart))
      else $error("copy count changed with no record");
   AST_FREQ_PPS: assert property ($rose(refPps) |-> ##[2:4] freqRefPps)
      else $error("reference pulse not passed on");
endmodule : tx_timing_props
bind tx_timing_ctl tx_timing_props #(.SYNC_CFG_W(SYNC_CFG_W)) props_u (.clk(clk),
   .sys_rst(sys_rst), .refPps(refPps), .tmValid(tmValid), .frameStart(frameStart),
   .syncCfg(syncCfg), .freqRefPps(freqRefPps), .idSigLevel(idSigLevel), .idSigOn(idSigOn),
   .preCopyCount(preCopyCount), .tmError(tmError), .preOutValid(preOutValid),
   .stageValid(stageValid), .stageSel(stageSel));
`default_nettype wire

// *** txctl_defs.svh ***
`ifndef TXCTL_DEFS_SVH
`define TXCTL_DEFS_SVH
// ==========================================================
// Timing constants and field positions
`define CLK_FREQ_HZ 10000000
`define TIME_W 32
`define TX_ID_SIG_LEVEL_RST 8'h00
`define COPY_CNT_RST 3'h1
// Time-of-day reference tick: one enable per microsecond
`define TICK_NS 1000
`define TICK_CYCLES ((`TICK_NS * (`CLK_FREQ_HZ / 1000000)) / 1000)
// Preamble record layout: length field leads, check word trails
`define PRE_LEN_BYTES 2
`define PRE_CHK_BYTES 2
`endif

// *** txctl_pkg.sv ***
`default_nettype none
package txctl_pkg;
   typedef enum logic [3:0]
   {
      PP_IDLE = 4'b0001,
      PP_LEN = 4'b0010,
      PP_BODY = 4'b0100,
      PP_HOLD = 4'b1000
   } pre_state_e;
   typedef logic [31:0] time_t;
endpackage : txctl_pkg
`default_nettype wire
